// *** pewc_host.sv ***
// module: host controller driving the byte-wide nonvolatile memory pins
`timescale 1ns/1ps
`default_nettype none
module pewc_host
    import pewc_pkg::*;
#(
    parameter int PAGE = PAGE_BYTES,
    parameter int GAP  = GAP_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic [1:0]        req_op,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_data,
    input  wire logic              req_last,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_data,
    output logic                   done_pulse,
    input  wire logic              supply_ok,
    input  wire logic              write_supply_ok,
    output logic [ADDR_W-1:0]      location_select,
    output logic                   chip_en_b,
    output logic                   out_en_b,
    output logic                   write_en_b,
    input  wire logic [DATA_W-1:0] byte_bus_i,
    output logic [DATA_W-1:0]      byte_bus_o,
    output logic                   byte_bus_oe
);
    typedef struct packed {
        pewc_state_t       st;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [ADDR_W-1:0] last_addr;
        logic [DATA_W-1:0] last_data;
        logic [6:0]        nbytes;
        logic              is_read;
        logic              poll;
        logic              ce_b;
        logic              oe_b;
        logic              we_b;
        logic              drive;
        logic              rsp_v;
        logic [DATA_W-1:0] rsp;
        logic              done;
        logic [2:0]        seq_left;
        logic              seq_mode;
        logic [DATA_W-1:0] seq_last;
    } pewc_reg_t;

    pewc_reg_t s_q, s_d;
    logic cnt_load;
    logic [CNT_W-1:0] cnt_val;
    logic cnt_zero;

    pewc_cnt #(.W(CNT_W)) u_cnt (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .load    (cnt_load),
        .value   (cnt_val),
        .zero    (cnt_zero)
    );

    // =========================================================
    // sequencer
    always_comb begin
        s_d = s_q;
        s_d.rsp_v = 1'b0;
        s_d.done = 1'b0;
        cnt_load = 1'b0;
        cnt_val = '0;
        case (s_q.st)
            PEWC_IDLE, PEWC_PGAP: begin
                if (s_q.st == PEWC_PGAP && cnt_zero) begin
                    s_d.st = PEWC_POLL;
                end else if (req_valid && req_ready) begin
                    s_d.is_read = (req_op == OP_READ);
                    s_d.poll = 1'b0;
                    if (req_op == OP_PROT_ON || req_op == OP_PROT_OFF) begin
                        s_d.seq_mode = 1'b1;
                        s_d.seq_left = 3'h2;
                        s_d.seq_last = (req_op == OP_PROT_ON) ? SEQ_ON : SEQ_OFF;
                        s_d.addr = SEQ_A0;
                        s_d.data = SEQ_D0;
                    end else begin
                        s_d.addr = req_addr;
                        s_d.data = req_data;
                    end
                    s_d.st = PEWC_SETUP;
                    cnt_load = 1'b1;
                    cnt_val = CNT_W'(SETUP_CYC);
                end
            end
            PEWC_SETUP: begin
                if (cnt_zero) begin
                    s_d.ce_b = 1'b0;
                    if (s_q.is_read || s_q.poll) begin
                        s_d.oe_b = 1'b0;
                        s_d.drive = 1'b0;
                        s_d.st = PEWC_RLOW;
                        cnt_val = CNT_W'(READ_CYC);
                    end else begin
                        s_d.oe_b = 1'b1;
                        s_d.we_b = 1'b0;
                        s_d.drive = 1'b1;
                        s_d.st = PEWC_WLOW;
                        cnt_val = CNT_W'(STROBE_CYC);
                    end
                    cnt_load = 1'b1;
                end
            end
            PEWC_WLOW: begin
                if (cnt_zero) begin
                    s_d.ce_b = 1'b1;
                    s_d.we_b = 1'b1;
                    s_d.last_addr = s_q.addr;
                    s_d.last_data = s_q.data;
                    s_d.nbytes = s_q.nbytes + 7'h1;
                    s_d.st = PEWC_WHIGH;
                    cnt_load = 1'b1;
                    cnt_val = CNT_W'(SETUP_CYC);
                end
            end
            PEWC_WHIGH: begin
                if (cnt_zero) begin
                    s_d.drive = 1'b0;
                    if (s_q.seq_mode && s_q.seq_left != 3'h0) begin
                        s_d.seq_left = s_q.seq_left - 3'h1;
                        s_d.addr = (s_q.seq_left == 3'h2) ? SEQ_A1 : SEQ_A0;
                        s_d.data = (s_q.seq_left == 3'h2) ? SEQ_D1 : s_q.seq_last;
                        s_d.st = PEWC_SETUP;
                        cnt_load = 1'b1;
                        cnt_val = CNT_W'(SETUP_CYC);
                    end else begin
                        s_d.seq_mode = 1'b0;
                        s_d.st = PEWC_PGAP;
                        cnt_load = 1'b1;
                        cnt_val = CNT_W'(GAP);
                        if (req_last || s_q.seq_mode ||
                            s_q.nbytes == 7'(PAGE)) begin
                            s_d.st = PEWC_POLL;
                        end
                    end
                end
            end
            PEWC_POLL: begin
                s_d.poll = 1'b1;
                s_d.nbytes = '0;
                s_d.addr = s_q.last_addr;
                s_d.st = PEWC_SETUP;
                cnt_load = 1'b1;
                cnt_val = CNT_W'(SETUP_CYC);
            end
            PEWC_RLOW: begin
                if (cnt_zero) begin
                    s_d.rsp = byte_bus_i;
                    s_d.ce_b = 1'b1;
                    s_d.oe_b = 1'b1;
                    s_d.st = s_q.poll ? PEWC_PCHK : PEWC_RDONE;
                end
            end
            PEWC_RDONE: begin
                s_d.rsp_v = 1'b1;
                s_d.st = PEWC_IDLE;
            end
            PEWC_PCHK: begin
                if (s_q.rsp[POLL_BIT] == s_q.last_data[POLL_BIT]) begin
                    s_d.done = 1'b1;
                    s_d.poll = 1'b0;
                    s_d.st = PEWC_IDLE;
                end else begin
                    s_d.st = PEWC_POLL;
                end
            end
            default: s_d.st = PEWC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{st: PEWC_IDLE, ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // =========================================================
    // outputs
    // page bits of a continued load are the caller's duty
    // only further page bytes are taken while the load window is open
    assign req_ready = (s_q.st == PEWC_IDLE ||
                        (s_q.st == PEWC_PGAP && !cnt_zero && req_op == OP_WRITE))
                       && supply_ok && (req_op == OP_READ || write_supply_ok);
    assign location_select = s_q.addr;
    assign chip_en_b = s_q.ce_b;
    assign out_en_b = s_q.oe_b;
    assign write_en_b = s_q.we_b;
    assign byte_bus_o = s_q.data;
    assign byte_bus_oe = s_q.drive;
    assign rsp_valid = s_q.rsp_v;
    assign rsp_data = s_q.rsp;
    assign done_pulse = s_q.done;

    // =========================================================
    // checks
    no_clash_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !(byte_bus_oe && !out_en_b)) else $error("bus drive clash");
    rd_strobes_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !out_en_b |-> !chip_en_b && write_en_b) else $error("bad read strobes");
    wr_strobes_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !write_en_b |-> out_en_b && byte_bus_oe) else $error("bad write strobes");
    addr_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !write_en_b && $past(!write_en_b) |-> $stable(location_select))
        else $error("address moved");
    data_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(write_en_b) |-> $stable(byte_bus_o)) else $error("data moved");
    we_width_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(write_en_b) |-> !write_en_b [*4]) else $error("short write pulse");
    gap_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_q.st == PEWC_WHIGH |-> ##[1:20] s_q.st != PEWC_WHIGH)
        else $error("stuck after load");
    supply_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_q.st == PEWC_IDLE && !supply_ok |=> s_q.st == PEWC_IDLE)
        else $error("access under low supply");
    poll_done_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        done_pulse |-> $past(s_q.rsp[POLL_BIT]) == s_q.last_data[POLL_BIT])
        else $error("early completion");
    rd_c: cover property (@(posedge ref_clk) disable iff (!rst_b) rsp_valid);
    done_c: cover property (@(posedge ref_clk) disable iff (!rst_b) done_pulse);
    page_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
        s_q.st == PEWC_PGAP && req_valid && req_ready);
endmodule
`default_nettype wire

// *** pewc_pkg.sv ***
// package: constants and types for the parallel memory write controller
package pewc_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int PAGE_BYTES = 64;
    localparam int PAGE_LSB = 6;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SETUP_NS = 100;
    localparam int STROBE_NS = 150;
    localparam int READ_NS = 200;
    localparam int GAP_MAX_US = 100;
    localparam int GAP_SAFE_US = 80;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC = (GAP_SAFE_US * 1000) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    localparam int POLL_BIT = DATA_W - 1;
    localparam logic [ADDR_W-1:0] SEQ_A0 = 15'h5555;
    localparam logic [ADDR_W-1:0] SEQ_A1 = 15'h2aaa;
    localparam logic [DATA_W-1:0] SEQ_D0 = 8'haa;
    localparam logic [DATA_W-1:0] SEQ_D1 = 8'h55;
    localparam logic [DATA_W-1:0] SEQ_ON = 8'ha0;
    localparam logic [DATA_W-1:0] SEQ_OFF = 8'h20;
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_PROT_ON = 2'h2;
    localparam logic [1:0] OP_PROT_OFF = 2'h3;
    typedef enum logic [3:0] {
        PEWC_IDLE  = 4'b0000,
        PEWC_SETUP = 4'b0001,
        PEWC_WLOW  = 4'b0010,
        PEWC_WHIGH = 4'b0011,
        PEWC_RLOW  = 4'b0100,
        PEWC_RDONE = 4'b0101,
        PEWC_PGAP  = 4'b0110,
        PEWC_POLL  = 4'b0111,
        PEWC_PCHK  = 4'b1000
    } pewc_state_t;
endpackage

// *** pewc_cnt.sv ***
// module: loadable down counter used for strobe and gap timing
`timescale 1ns/1ps
`default_nettype none
module pewc_cnt #(
    parameter int W = 12
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              zero
);
    logic [W-1:0] cnt_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= value;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
    assign zero = (cnt_q == '0);
endmodule
`default_nettype wire

// *** pewc_mem_model.sv ***
// partner model: behavioural byte-wide nonvolatile memory
`timescale 1ns/1ps
`default_nettype none
module pewc_mem_model
    import pewc_pkg::*;
#(
    parameter int LOAD_NS = 2500,
    parameter int PROG_NS = 3000
) (
    input  wire logic [ADDR_W-1:0] location_select,
    input  wire logic              chip_en_b,
    input  wire logic              out_en_b,
    input  wire logic              write_en_b,
    input  wire logic [DATA_W-1:0] bus_in,
    output logic [DATA_W-1:0]      dev_d,
    output logic                   dev_oe
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [ADDR_W-1:0] a_q;
    logic [ADDR_W-1:0] last_a;
    logic [DATA_W-1:0] last_d;
    logic              loading;
    logic              busy;
    logic              prot;
    logic              token;
    logic              used;
    logic              seq_byte;
    int                seq;
    realtime           t_last;
    realtime           t_end;
    wire               wr = !chip_en_b && !write_en_b && out_en_b;
    initial begin
        {loading, busy, prot, token, used, last_a, last_d} = '0;
        seq = 0;
        for (int i = 0; i < (1<<ADDR_W); i++) begin
            mem[i] = 8'hff;
        end
    end
    // ==========================================
    // address on later falling strobe
    always @(posedge wr) begin
        a_q = location_select;
        t_last = $realtime;
    end
    // data on first rising strobe, sequence tracking
    always @(negedge wr) begin
        seq_byte = 1'b1;
        if (seq == 2 && a_q == SEQ_A0 && (bus_in == SEQ_ON || bus_in == SEQ_OFF)) begin
            prot = (bus_in == SEQ_ON);
            token = 1'b1;
            seq = 0;
        end else if (seq == 1 && a_q == SEQ_A1 && bus_in == SEQ_D1) begin
            seq = 2;
        end else begin
            seq_byte = (a_q == SEQ_A0 && bus_in == SEQ_D0);
            seq = seq_byte ? 1 : 0;
        end
        if (!busy && (seq_byte || !prot || token)) begin
            mem[a_q] = bus_in;
            last_a = a_q;
            last_d = bus_in;
            loading = 1'b1;
            used = used | (prot && !seq_byte);
        end
    end
    // ==========================================
    // load window and programming timer
    always #25 begin
        if (loading && $realtime - t_last > LOAD_NS) begin
            loading = 1'b0;
            busy = 1'b1;
            t_end = $realtime + PROG_NS;
        end else if (busy && $realtime >= t_end) begin
            busy = 1'b0;
            token = token && !used;
            used = 1'b0;
        end
    end
    assign dev_oe = !chip_en_b && !out_en_b;
    assign dev_d = ((loading || busy) && location_select == last_a) ?
                   {~last_d[POLL_BIT], last_d[POLL_BIT-1:0]} : mem[location_select];
endmodule
`default_nettype wire

// *** pewc_host_tb.sv ***
// testbench: host controller against the memory model
`timescale 1ns/1ps
`default_nettype none
module pewc_host_tb
    import pewc_pkg::*;
;
    logic              ref_clk = 1'b0;
    logic              rst_b;
    logic              req_valid;
    logic              req_last;
    logic              supply_ok;
    logic              write_supply_ok;
    logic [1:0]        req_op;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_data;
    logic              req_ready;
    logic              rsp_valid;
    logic              done_pulse;
    logic              chip_en_b;
    logic              out_en_b;
    logic              write_en_b;
    logic              byte_bus_oe;
    logic              dev_oe;
    logic [ADDR_W-1:0] location_select;
    logic [DATA_W-1:0] rsp_data;
    logic [DATA_W-1:0] byte_bus_o;
    logic [DATA_W-1:0] dev_d;
    logic [DATA_W-1:0] idle_q = 8'h5a;
    wire  [DATA_W-1:0] bus = byte_bus_oe ? byte_bus_o : (dev_oe ? dev_d : idle_q);
    int                miscompares = 0;
    int                num_checks = 0;
    int                cycles = 0;
    pewc_host #(.GAP(50)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
        .req_last(req_last), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .done_pulse(done_pulse), .supply_ok(supply_ok), .write_supply_ok(write_supply_ok),
        .location_select(location_select), .chip_en_b(chip_en_b), .out_en_b(out_en_b),
        .write_en_b(write_en_b), .byte_bus_i(bus), .byte_bus_o(byte_bus_o),
        .byte_bus_oe(byte_bus_oe));
    pewc_mem_model mem_u (.location_select(location_select), .chip_en_b(chip_en_b),
        .out_en_b(out_en_b), .write_en_b(write_en_b), .bus_in(bus), .dev_d(dev_d),
        .dev_oe(dev_oe));
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        idle_q <= ~idle_q;
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            complete_run();
        end
    end
    // ==========================================
    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(negedge ref_clk) begin
        if (rst_b && byte_bus_oe === 1'b1 && out_en_b !== 1'b1) check(1'b0, "contention");
        if (rst_b && write_en_b === 1'b0 && out_en_b !== 1'b1) check(1'b0, "write+read");
    end
    task automatic send(input logic [1:0] op, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic last);
        int n;
        n = 0;
        req_op <= op;
        req_addr <= a;
        req_data <= d;
        req_last <= last;
        req_valid <= 1'b1;
        @(negedge ref_clk);
        while (req_ready !== 1'b1 && n < 4000) begin
            @(negedge ref_clk);
            n++;
        end
        check(n < 4000, "request not taken");
        @(posedge ref_clk);
        req_valid <= 1'b0;
        if (op == OP_WRITE) begin
            wait (write_en_b === 1'b0);
            wait (write_en_b === 1'b1);
            repeat (6) @(posedge ref_clk);
        end
    endtask
    task automatic wait_done(input int min_cyc);
        int n;
        n = 0;
        while (done_pulse !== 1'b1 && n < 20000) begin
            @(negedge ref_clk);
            n++;
        end
        check(n >= min_cyc && n < 20000, "completion timing");
        @(posedge ref_clk);
    endtask
    task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        int n;
        n = 0;
        send(OP_READ, a, 8'h00, 1'b0);
        while (rsp_valid !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        check(n < 100 && rsp_data === exp, "read data");
        @(posedge ref_clk);
    endtask
    // ==========================================
    task automatic t_byte();
        send(OP_WRITE, 15'h7fff, 8'h3c, 1'b1);
        wait_done(120);
        read_chk(15'h7fff, 8'h3c);
        read_chk(15'h3fff, 8'hff);
    endtask
    task automatic t_page();
        send(OP_WRITE, 15'h0140, 8'ha1, 1'b0);
        req_op <= OP_READ;
        req_valid <= 1'b1;
        @(negedge ref_clk);
        check(req_ready === 1'b0, "read taken inside page load");
        @(posedge ref_clk);
        send(OP_WRITE, 15'h0141, 8'h02, 1'b0);
        send(OP_WRITE, 15'h017f, 8'hc3, 1'b0);
        wait_done(120);
        read_chk(15'h0140, 8'ha1);
        read_chk(15'h0141, 8'h02);
        read_chk(15'h017f, 8'hc3);
    endtask
    task automatic t_full();
        for (int i = 0; i < PAGE_BYTES; i++) begin
            send(OP_WRITE, 15'h0400 + 15'(i), 8'(i), 1'b0);
        end
        @(negedge ref_clk);
        check(req_ready === 1'b0, "page not closed at full size");
        wait_done(120);
        read_chk(15'h0400, 8'h00);
        read_chk(15'h043f, 8'h3f);
    endtask
    task automatic t_prot();
        send(OP_PROT_ON, SEQ_A0, 8'h00, 1'b1);
        wait_done(0);
        send(OP_WRITE, 15'h0200, 8'h11, 1'b1);
        wait_done(120);
        send(OP_WRITE, 15'h0200, 8'h22, 1'b1);
        wait_done(0);
        read_chk(15'h0200, 8'h11);
        send(OP_PROT_OFF, SEQ_A0, 8'h00, 1'b1);
        wait_done(0);
        send(OP_WRITE, 15'h0200, 8'h33, 1'b1);
        wait_done(120);
        read_chk(15'h0200, 8'h33);
    endtask
    task automatic t_supply();
        supply_ok <= 1'b0;
        req_op <= OP_READ;
        req_valid <= 1'b1;
        repeat (3) @(negedge ref_clk);
        check(req_ready === 1'b0, "ready while supply low");
        @(posedge ref_clk);
        supply_ok <= 1'b1;
        write_supply_ok <= 1'b0;
        req_op <= OP_WRITE;
        repeat (3) @(negedge ref_clk);
        check(req_ready === 1'b0, "write ready while write supply low");
        @(posedge ref_clk);
        req_valid <= 1'b0;
        @(posedge ref_clk);
        read_chk(15'h7fff, 8'h3c);
        write_supply_ok <= 1'b1;
    endtask
    initial begin
        rst_b = 1'b0;
        req_valid = 1'b0;
        req_op = OP_READ;
        req_addr = '0;
        req_data = '0;
        req_last = 1'b0;
        supply_ok = 1'b1;
        write_supply_ok = 1'b1;
        repeat (10) @(posedge ref_clk);
        check(chip_en_b === 1'b1 && write_en_b === 1'b1 && byte_bus_oe === 1'b0, "reset pins");
        rst_b <= 1'b1;
        @(posedge ref_clk);
        t_byte();
        t_page();
        t_full();
        t_prot();
        t_supply();
        complete_run();
    end
endmodule
`default_nettype wire
